// ### src/hpc_dev.sv
// Terminal end of the parallel host port control logic.
//
// Contract
// - 16-bit buffered: polarity strap sets read sense.
// - 8-bit buffered: polarity strap sets byte-lane sense.
// - Transparent: accept low after bus grant.
// - Own RAM transfers only while accept low.
// - Byte order select: high means MSB first.
// - Byte order ignored in 16-bit mode.
// - Shared RAM select is internal RAM chip select.
// - Host logic ORs accept and io strobe.
// - Space select: 1 memory, 0 register.
// - Interface style strap: 0 buffered, 1 transparent.
// - Width select: 1 16-bit, 0 8-bit.
// - Arbiter grants bus after bus request.
// - Otherwise read/write high means read.
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`include "hpc_regs.svh"
module hpc_dev #(
  parameter int RAM_AW = 8,
  parameter int REG_AW = 2
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Host port pins.
  hpc_if.dev bus,
  // Own transfer request.
  input wire logic i_dma_req,
  input wire logic i_dma_write,
  input wire logic [15:0] i_dma_addr,
  input wire logic [15:0] i_dma_wdata,
  output logic o_dma_busy,
  output logic o_dma_done,
  output logic [15:0] o_dma_rdata,
  // Host access report and status.
  input wire logic [15:0] i_status,
  output logic o_host_wr,
  output logic o_host_wr_space,
  output logic [15:0] o_host_wr_addr,
  output logic [15:0] o_host_wr_data,
  output logic o_mode_transparent,
  output logic o_mode_16bit
);
  // ==========================================================
  // Pin synchronisers.
  // Active-low pins are inverted ahead of the first stage so that reset clears them.
  localparam int SW = 42;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] pins;
  assign pins = {bus.interface_style, bus.width_select, bus.polarity_select,
    bus.byte_order_select, bus.read_write_select, bus.byte_lane_select,
    bus.space_select, ~bus.host_strobe_n, ~bus.bus_grant_n,
    ~bus.shared_ram_select_n, bus.addr_bus, bus.data_bus};
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end
  logic s_style, s_width, s_pol, s_order, s_rw, s_lane, s_space;
  logic s_strobe, s_grant, s_ramsel;
  logic [15:0] s_addr;
  logic [15:0] s_data;
  assign {s_style, s_width, s_pol, s_order, s_rw, s_lane, s_space,
    s_strobe, s_grant, s_ramsel, s_addr, s_data} = sync2;
  // ==========================================================
  // Mode and access decode.
  // Straps are only read as steady levels, so no capture is needed.
  logic transparent, bus16, is_read, is_msb, msb_first;
  hpc_decode u_decode (
    .i_style(s_style),
    .i_width(s_width),
    .i_pol(s_pol),
    .i_order(s_order),
    .i_rw(s_rw),
    .i_lane(s_lane),
    .o_transparent(transparent),
    .o_bus16(bus16),
    .o_is_read(is_read),
    .o_is_msb(is_msb),
    .o_msb_first(msb_first)
  );
  assign o_mode_transparent = transparent;
  assign o_mode_16bit = bus16;
  // ==========================================================
  // Storage.
  logic [15:0] ram [0:(1<<RAM_AW)-1];
  logic [15:0] regs [0:(1<<REG_AW)-1];
  // ==========================================================
  // Buffered host access.
  logic strobe_q;
  logic next_strobe_q;
  logic [7:0] pend;
  logic [7:0] next_pend;
  logic [15:0] rd_word;
  logic [15:0] next_rd_word;
  logic [15:0] hdata;
  logic [15:0] next_hdata;
  logic hdata_oe;
  logic next_hdata_oe;
  logic start;
  logic first_byte;
  logic [15:0] src_word;
  logic [15:0] wr_word;
  logic do_wr;
  logic [RAM_AW-1:0] ram_a;
  logic [REG_AW-1:0] reg_a;
  assign ram_a = s_addr[RAM_AW-1:0];
  assign reg_a = s_addr[REG_AW-1:0];
  assign start = s_strobe & ~strobe_q & ~transparent;
  assign first_byte = (is_msb == msb_first);
  always_comb begin
    next_strobe_q = s_strobe;
    next_pend = pend;
    next_rd_word = rd_word;
    next_hdata = hdata;
    next_hdata_oe = hdata_oe & s_strobe & ~transparent;
    do_wr = 1'b0;
    wr_word = s_data;
    if (s_space) begin
      src_word = ram[ram_a];
    end else if (reg_a == '0) begin
      src_word = i_status;
    end else begin
      src_word = regs[reg_a];
    end
    if (start) begin
      if (is_read) begin
        next_hdata_oe = 1'b1;
        if (bus16) begin
          next_hdata = src_word;
        end else if (first_byte) begin
          next_rd_word = src_word;
          next_hdata = {8'h00, is_msb ? src_word[15:8] : src_word[7:0]};
        end else begin
          next_hdata = {8'h00, is_msb ? rd_word[15:8] : rd_word[7:0]};
        end
      end else if (bus16) begin
        do_wr = 1'b1;
      end else if (first_byte) begin
        next_pend = s_data[7:0];
      end else begin
        do_wr = 1'b1;
        wr_word = is_msb ? {s_data[7:0], pend} : {pend, s_data[7:0]};
      end
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      strobe_q <= 1'b0;
      pend <= 8'h00;
      rd_word <= 16'h0000;
      hdata <= 16'h0000;
      hdata_oe <= 1'b0;
      o_host_wr <= 1'b0;
      o_host_wr_space <= 1'b0;
      o_host_wr_addr <= 16'h0000;
      o_host_wr_data <= 16'h0000;
    end else begin
      strobe_q <= next_strobe_q;
      pend <= next_pend;
      rd_word <= next_rd_word;
      hdata <= next_hdata;
      hdata_oe <= next_hdata_oe;
      o_host_wr <= do_wr;
      if (do_wr) begin
        o_host_wr_space <= s_space;
        o_host_wr_addr <= s_addr;
        o_host_wr_data <= wr_word;
      end
    end
  end
  // ==========================================================
  // Own transfers in transparent mode.
  hpc_pkg::hpc_dev_state_t state;
  hpc_pkg::hpc_dev_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic ram_hit;
  logic next_ram_hit;
  logic [15:0] next_dma_rdata;
  logic next_dma_done;
  logic ram_take;
  logic [RAM_AW-1:0] dma_a;
  assign dma_a = i_dma_addr[RAM_AW-1:0];
  // A transfer holds the bus long enough for the synchronised chip select to arrive.
  assign ram_take = (state == hpc_pkg::HPC_D_XFER) & s_ramsel & ~ram_hit;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ram_hit = ram_hit | ram_take;
    next_dma_rdata = o_dma_rdata;
    next_dma_done = 1'b0;
    case (state)
      hpc_pkg::HPC_D_IDLE: begin
        next_ram_hit = 1'b0;
        next_cnt = 4'h0;
        // A request still held while done shows is the old one, not a new one.
        if (i_dma_req && transparent && !o_dma_done) begin
          next_state = hpc_pkg::HPC_D_REQ;
        end
      end
      hpc_pkg::HPC_D_REQ: begin
        if (s_grant) begin
          next_state = hpc_pkg::HPC_D_XFER;
        end
      end
      hpc_pkg::HPC_D_XFER: begin
        next_cnt = cnt + 4'h1;
        if (ram_take && !i_dma_write) begin
          next_dma_rdata = ram[dma_a];
        end
        if (cnt == `HPC_IOSTB_CYC) begin
          if (!i_dma_write && !ram_hit) begin
            next_dma_rdata = s_data;
          end
          next_state = hpc_pkg::HPC_D_DONE;
        end
      end
      hpc_pkg::HPC_D_DONE: begin
        next_dma_done = 1'b1;
        next_state = hpc_pkg::HPC_D_IDLE;
      end
      default: begin
        next_state = hpc_pkg::HPC_D_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= hpc_pkg::HPC_D_IDLE;
      cnt <= 4'h0;
      ram_hit <= 1'b0;
      o_dma_rdata <= 16'h0000;
      o_dma_done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ram_hit <= next_ram_hit;
      o_dma_rdata <= next_dma_rdata;
      o_dma_done <= next_dma_done;
    end
  end
  // ==========================================================
  // Memory and register writes.
  always_ff @(posedge i_sys_clk) begin
    if (ram_take && i_dma_write) begin
      ram[dma_a] <= i_dma_wdata;
    end else if (do_wr && s_space) begin
      ram[ram_a] <= wr_word;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < (1 << REG_AW); i++) begin
        regs[i] <= 16'h0000;
      end
    end else if (do_wr && !s_space && reg_a != '0) begin
      regs[reg_a] <= wr_word;
    end
  end
  // ==========================================================
  // Pin drive.
  logic xfer;
  assign xfer = (state == hpc_pkg::HPC_D_XFER);
  assign o_dma_busy = (state != hpc_pkg::HPC_D_IDLE);
  assign bus.bus_request_n = ~(state == hpc_pkg::HPC_D_REQ || xfer);
  assign bus.transfer_accept_n = ~xfer;
  assign bus.io_strobe_out_n = ~(xfer && cnt < `HPC_IOSTB_CYC);
  assign bus.dev_addr_out = i_dma_addr;
  assign bus.dev_addr_oe = xfer;
  assign bus.dev_rw_out = ~i_dma_write;
  assign bus.dev_rw_oe = xfer;
  assign bus.dev_data_out = xfer ? i_dma_wdata : hdata;
  assign bus.dev_data_oe = (xfer & i_dma_write) | hdata_oe;
endmodule : hpc_dev

// ### common/hpc_regs.svh
// Constants for the host port control straps block.
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
// ==========================================================
// Host side register word indices on the Avalon-MM port.
`define HPC_REG_CTRL 3'h0
`define HPC_REG_ADDR 3'h1
`define HPC_REG_WDATA 3'h2
`define HPC_REG_CMD 3'h3
`define HPC_REG_STATUS 3'h4
`define HPC_REG_RDATA 3'h5
// ==========================================================
// Control, address and command register field positions and control reset value.
`define HPC_CTRL_STYLE 0
`define HPC_CTRL_WIDTH 1
`define HPC_CTRL_POL 2
`define HPC_CTRL_ORDER 3
`define HPC_CTRL_GRANT 4
`define HPC_CTRL_RST 5'h02
`define HPC_ADDR_SPACE 16
`define HPC_CMD_GO 0
`define HPC_CMD_READ 1
// ==========================================================
// Timing counts in clock cycles.
`define HPC_STROBE_CYC 4'h8
`define HPC_GAP_CYC 4'h4
`define HPC_IOSTB_CYC 4'h4
`endif

// ### common/hpc_pkg.sv
// Types shared by both ends of the host port control block.
package hpc_pkg;
  typedef enum logic [1:0] {
    HPC_D_IDLE = 2'b00,
    HPC_D_REQ = 2'b01,
    HPC_D_XFER = 2'b10,
    HPC_D_DONE = 2'b11
  } hpc_dev_state_t;
  typedef enum logic [1:0] {
    HPC_H_IDLE = 2'b00,
    HPC_H_SETUP = 2'b01,
    HPC_H_STROBE = 2'b10,
    HPC_H_GAP = 2'b11
  } hpc_host_state_t;
endpackage : hpc_pkg

// ### common/hpc_if.sv
// Parallel host port pins between the terminal and its host.
interface hpc_if;
  // ==========================================================
  // Straps and buffered access controls, host driven.
  logic interface_style;
  logic width_select;
  logic polarity_select;
  logic byte_order_select;
  logic byte_lane_select;
  logic space_select;
  logic host_strobe_n;
  // ==========================================================
  // Shared address, data and direction lines.
  logic [15:0] host_addr_out;
  logic host_addr_oe;
  logic [15:0] dev_addr_out;
  logic dev_addr_oe;
  logic [15:0] host_data_out;
  logic host_data_oe;
  logic [15:0] dev_data_out;
  logic dev_data_oe;
  logic host_rw_out;
  logic host_rw_oe;
  logic dev_rw_out;
  logic dev_rw_oe;
  logic [15:0] addr_bus;
  logic [15:0] data_bus;
  logic read_write_select;
  // ==========================================================
  // Transparent mode bus handover.
  logic bus_request_n;
  logic bus_grant_n;
  logic transfer_accept_n;
  logic io_strobe_out_n;
  logic shared_ram_select_n;
  // Undriven lines read as pulled high.
  assign addr_bus = dev_addr_oe ? dev_addr_out : (host_addr_oe ? host_addr_out : 16'hFFFF);
  assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 16'hFFFF);
  assign read_write_select = dev_rw_oe ? dev_rw_out : (host_rw_oe ? host_rw_out : 1'b1);
  modport dev (
    input interface_style, width_select, polarity_select, byte_order_select,
    input byte_lane_select, space_select, host_strobe_n, addr_bus, data_bus,
    input read_write_select, bus_grant_n, shared_ram_select_n,
    output dev_addr_out, dev_addr_oe, dev_data_out, dev_data_oe, dev_rw_out, dev_rw_oe,
    output bus_request_n, transfer_accept_n, io_strobe_out_n
  );
  modport host (
    output interface_style, width_select, polarity_select, byte_order_select,
    output byte_lane_select, space_select, host_strobe_n,
    output host_addr_out, host_addr_oe, host_data_out, host_data_oe, host_rw_out, host_rw_oe,
    output bus_grant_n, shared_ram_select_n,
    input data_bus, bus_request_n, transfer_accept_n, io_strobe_out_n
  );
endinterface : hpc_if

// ### src/hpc_decode.sv
// Decode of strap levels and per-access direction and byte lane.
module hpc_decode (
  // Strap levels.
  input wire logic i_style,
  input wire logic i_width,
  input wire logic i_pol,
  input wire logic i_order,
  // Access controls.
  input wire logic i_rw,
  input wire logic i_lane,
  // Decoded mode and access.
  output logic o_transparent,
  output logic o_bus16,
  output logic o_is_read,
  output logic o_is_msb,
  output logic o_msb_first
);
  always_comb begin
    o_transparent = i_style;
    o_bus16 = ~i_style & i_width;
    o_is_read = i_rw ^ (o_bus16 & ~i_pol);
    o_is_msb = i_lane ^ i_pol;
    o_msb_first = ~o_bus16 & i_order;
  end
endmodule : hpc_decode

// ### src/hpc_host.sv
// Host end of the parallel port, driven from Avalon-MM registers.
`include "hpc_regs.svh"
module hpc_host (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Avalon-MM slave.
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Host port pins.
  hpc_if.host bus
);
  // ==========================================================
  // Pin synchronisers.
  logic [18:0] sync1;
  logic [18:0] sync2;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {~bus.bus_request_n, ~bus.transfer_accept_n, ~bus.io_strobe_out_n, bus.data_bus};
      sync2 <= sync1;
    end
  end
  // ==========================================================
  // Registers and bus slave.
  // Waitrequest is held for one cycle, so every access ends on its second edge.
  logic [4:0] ctrl;
  logic [16:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic go;
  logic busy;
  hpc_pkg::hpc_host_state_t state;
  hpc_pkg::hpc_host_state_t next_state;
  logic do_read;
  logic next_do_read;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic byte_ix;
  logic next_byte_ix;
  logic [15:0] next_rdata;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign busy = (state != hpc_pkg::HPC_H_IDLE);
  assign go = i_avs_write & ack & (i_avs_address == `HPC_REG_CMD)
    & i_avs_writedata[`HPC_CMD_GO] & ~busy;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ack <= 1'b0;
      ctrl <= `HPC_CTRL_RST;
      addr <= 17'h0_0000;
      wdata <= 16'h0000;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= (i_avs_read | i_avs_write) & ~ack;
      if (i_avs_write && ack) begin
        case (i_avs_address)
          `HPC_REG_CTRL: ctrl <= i_avs_writedata[4:0];
          `HPC_REG_ADDR: addr <= i_avs_writedata[16:0];
          `HPC_REG_WDATA: wdata <= i_avs_writedata[15:0];
          default: ;
        endcase
      end
      if (i_avs_read && !ack) begin
        case (i_avs_address)
          `HPC_REG_CTRL: o_avs_readdata <= {27'h000_0000, ctrl};
          `HPC_REG_ADDR: o_avs_readdata <= {15'h0000, addr};
          `HPC_REG_WDATA: o_avs_readdata <= {16'h0000, wdata};
          `HPC_REG_STATUS: o_avs_readdata <= {28'h000_0000, sync2[17], sync2[18], ~bus.bus_grant_n, busy};
          `HPC_REG_RDATA: o_avs_readdata <= {16'h0000, rdata};
          default: o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ==========================================================
  // Access sequencer.
  logic bus16, is_msb, is_msb_first;
  hpc_decode u_decode (
    .i_style(ctrl[`HPC_CTRL_STYLE]),
    .i_width(ctrl[`HPC_CTRL_WIDTH]),
    .i_pol(ctrl[`HPC_CTRL_POL]),
    .i_order(ctrl[`HPC_CTRL_ORDER]),
    .i_rw(1'b0),
    .i_lane(1'b0),
    .o_transparent(),
    .o_bus16(bus16),
    .o_is_read(),
    .o_is_msb(),
    .o_msb_first(is_msb_first)
  );
  assign is_msb = byte_ix ^ is_msb_first;
  always_comb begin
    next_state = state;
    next_cnt = cnt + 4'h1;
    next_byte_ix = byte_ix;
    next_do_read = do_read;
    next_rdata = rdata;
    case (state)
      hpc_pkg::HPC_H_IDLE: begin
        next_cnt = 4'h0;
        next_byte_ix = 1'b0;
        if (go && !ctrl[`HPC_CTRL_STYLE]) begin
          next_do_read = i_avs_writedata[`HPC_CMD_READ];
          next_state = hpc_pkg::HPC_H_SETUP;
        end
      end
      hpc_pkg::HPC_H_SETUP: begin
        next_cnt = 4'h0;
        next_state = hpc_pkg::HPC_H_STROBE;
      end
      hpc_pkg::HPC_H_STROBE: begin
        if (cnt == `HPC_STROBE_CYC - 4'h1) begin
          if (do_read && bus16) begin
            next_rdata = sync2[15:0];
          end else if (do_read && is_msb) begin
            next_rdata = {sync2[7:0], rdata[7:0]};
          end else if (do_read) begin
            next_rdata = {rdata[15:8], sync2[7:0]};
          end
          next_cnt = 4'h0;
          next_state = hpc_pkg::HPC_H_GAP;
        end
      end
      hpc_pkg::HPC_H_GAP: begin
        if (cnt == `HPC_GAP_CYC - 4'h1) begin
          next_byte_ix = 1'b1;
          next_state = (bus16 || byte_ix) ? hpc_pkg::HPC_H_IDLE : hpc_pkg::HPC_H_SETUP;
        end
      end
      default: begin
        next_state = hpc_pkg::HPC_H_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= hpc_pkg::HPC_H_IDLE;
      cnt <= 4'h0;
      byte_ix <= 1'b0;
      do_read <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      byte_ix <= next_byte_ix;
      do_read <= next_do_read;
      rdata <= next_rdata;
    end
  end
  // ==========================================================
  // Pin drive.
  logic active;
  assign active = (state == hpc_pkg::HPC_H_SETUP) | (state == hpc_pkg::HPC_H_STROBE);
  assign bus.interface_style = ctrl[`HPC_CTRL_STYLE];
  assign bus.width_select = ctrl[`HPC_CTRL_WIDTH];
  assign bus.polarity_select = ctrl[`HPC_CTRL_POL];
  assign bus.byte_order_select = ctrl[`HPC_CTRL_ORDER];
  assign bus.byte_lane_select = is_msb ^ ctrl[`HPC_CTRL_POL];
  assign bus.space_select = addr[`HPC_ADDR_SPACE];
  assign bus.host_strobe_n = ~(state == hpc_pkg::HPC_H_STROBE);
  assign bus.host_addr_out = addr[15:0];
  assign bus.host_addr_oe = ~ctrl[`HPC_CTRL_STYLE];
  assign bus.host_rw_out = do_read ^ (bus16 & ~ctrl[`HPC_CTRL_POL]);
  assign bus.host_rw_oe = ~ctrl[`HPC_CTRL_STYLE];
  assign bus.host_data_out = bus16 ? wdata : {8'h00, is_msb ? wdata[15:8] : wdata[7:0]};
  assign bus.host_data_oe = active & ~do_read;
  assign bus.bus_grant_n = ~(ctrl[`HPC_CTRL_GRANT] & sync2[18]);
  assign bus.shared_ram_select_n = bus.transfer_accept_n | bus.io_strobe_out_n;
endmodule : hpc_host

// ### testbench/hpc_assertions.sv
// Concurrent checks on the pins that join the two ends of the host port.
module hpc_assertions (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Straps and access controls.
  input wire logic interface_style,
  input wire logic width_select,
  input wire logic polarity_select,
  input wire logic host_strobe_n,
  input wire logic read_write_select,
  // Device drive enables.
  input wire logic dev_addr_oe,
  input wire logic dev_data_oe,
  input wire logic dev_rw_oe,
  // Bus handover.
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic transfer_accept_n,
  input wire logic io_strobe_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Transparent mode handover.
  property p_accept_after_grant;
    $fell(transfer_accept_n) |-> !$past(bus_grant_n);
  endproperty
  a_accept_after_grant: assert property (p_accept_after_grant)
    else $error("accept fell without a prior grant");
  property p_accept_in_grant;
    !transfer_accept_n |-> !bus_grant_n && !bus_request_n;
  endproperty
  a_accept_in_grant: assert property (p_accept_in_grant)
    else $error("accept low outside request and grant");
  property p_drive_in_accept;
    interface_style && (dev_addr_oe || dev_data_oe || dev_rw_oe) |-> !transfer_accept_n;
  endproperty
  a_drive_in_accept: assert property (p_drive_in_accept)
    else $error("device drives the bus while accept is high");
  property p_iostb_in_accept;
    !io_strobe_out_n |-> !transfer_accept_n;
  endproperty
  a_iostb_in_accept: assert property (p_iostb_in_accept)
    else $error("io strobe low outside the accept interval");
  property p_iostb_width;
    $fell(io_strobe_out_n) |-> (!io_strobe_out_n)[*4] ##1 io_strobe_out_n;
  endproperty
  a_iostb_width: assert property (p_iostb_width)
    else $error("io strobe not low for four cycles");
  property p_request_mode;
    !bus_request_n |-> interface_style;
  endproperty
  a_request_mode: assert property (p_request_mode)
    else $error("bus request in buffered mode");
  property p_addr_mode;
    dev_addr_oe |-> interface_style;
  endproperty
  a_addr_mode: assert property (p_addr_mode)
    else $error("device drives address in buffered mode");
  // ==========================================================
  // Buffered read direction.
  property p_read_sense;
    !interface_style && $rose(dev_data_oe) |->
      !$past(host_strobe_n) && ($past(read_write_select) == (polarity_select || !width_select));
  endproperty
  a_read_sense: assert property (p_read_sense)
    else $error("device drove data on a cycle that is not a read");
  c_transfer: cover property ($fell(transfer_accept_n));
  c_read16: cover property (!interface_style && width_select && $rose(dev_data_oe));
  c_read8: cover property (!interface_style && !width_select && $rose(dev_data_oe));
endmodule : hpc_assertions

// ### testbench/tb_hpc.sv
// Testbench joining both ends of the host port and driving their user sides.
`include "hpc_regs.svh"
module tb_hpc;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst;
  logic [2:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic dma_req;
  logic dma_write;
  logic [15:0] dma_addr;
  logic [15:0] dma_wdata;
  logic dma_done;
  logic dma_busy;
  logic [15:0] dma_rdata;
  logic [15:0] status;
  logic host_wr_space;
  logic [15:0] host_wr_addr;
  logic [15:0] host_wr_data;
  logic mode_t;
  logic mode_16;
  logic [31:0] q;
  logic [15:0] q16;
  logic [15:0] d;
  int bad_count;
  int tests_run;
  hpc_if bus_if();
  hpc_host hpc_host_i (.i_sys_clk(clk), .i_rst(rst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .bus(bus_if));
  hpc_dev hpc_dev_i (.i_sys_clk(clk), .i_rst(rst), .bus(bus_if), .i_dma_req(dma_req),
    .i_dma_write(dma_write), .i_dma_addr(dma_addr), .i_dma_wdata(dma_wdata), .o_dma_busy(dma_busy),
    .o_dma_done(dma_done), .o_dma_rdata(dma_rdata), .i_status(status), .o_host_wr(),
    .o_host_wr_space(host_wr_space), .o_host_wr_addr(host_wr_addr),
    .o_host_wr_data(host_wr_data), .o_mode_transparent(mode_t), .o_mode_16bit(mode_16));
  hpc_assertions hpc_assertions_i (.i_sys_clk(clk), .i_rst(rst),
    .interface_style(bus_if.interface_style), .width_select(bus_if.width_select),
    .polarity_select(bus_if.polarity_select), .host_strobe_n(bus_if.host_strobe_n),
    .read_write_select(bus_if.read_write_select), .dev_addr_oe(bus_if.dev_addr_oe),
    .dev_data_oe(bus_if.dev_data_oe), .dev_rw_oe(bus_if.dev_rw_oe),
    .bus_request_n(bus_if.bus_request_n), .bus_grant_n(bus_if.bus_grant_n),
    .transfer_accept_n(bus_if.transfer_accept_n), .io_strobe_out_n(bus_if.io_strobe_out_n));
  // ==========================================================
  // Shared tasks.
  task automatic conclude();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // The request is held until an edge with waitrequest low; no latency is assumed.
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  task automatic hacc(input logic rd, input logic sp, input logic [15:0] a,
                      input logic [15:0] wd, output logic [15:0] got);
    logic [31:0] r;
    av(1'b1, `HPC_REG_ADDR, {15'h0000, sp, a}, r);
    av(1'b1, `HPC_REG_WDATA, {16'h0000, wd}, r);
    av(1'b1, `HPC_REG_CMD, {30'h0000_0000, rd, 1'b1}, r);
    do begin
      av(1'b0, `HPC_REG_STATUS, 32'h0000_0000, r);
    end while (r[0] !== 1'b0);
    av(1'b0, `HPC_REG_RDATA, 32'h0000_0000, r);
    got = r[15:0];
  endtask : hacc
  // Straps pass two synchroniser stages, so a few cycles settle them.
  task automatic ctrl(input logic [4:0] v);
    logic [31:0] r;
    av(1'b1, `HPC_REG_CTRL, {27'h000_0000, v}, r);
    repeat (4) @(posedge clk);
  endtask : ctrl
  task automatic dma(input logic wr, input logic [15:0] a, input logic [15:0] wd);
    @(posedge clk);
    dma_req <= 1'b1;
    dma_write <= wr;
    dma_addr <= a;
    dma_wdata <= wd;
    do begin
      @(posedge clk);
    end while (dma_done !== 1'b1);
    dma_req <= 1'b0;
  endtask : dma
  // ==========================================================
  // Clock, watchdog and test sequence.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    dma_req = 1'b0;
    dma_write = 1'b0;
    dma_addr = 16'h0000;
    dma_wdata = 16'h0000;
    status = 16'hBEEF;
    bad_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, `HPC_REG_CTRL, 32'h0000_0000, q);
    chk("ctrl reset", {11'h000, `HPC_CTRL_RST}, q[15:0]);
    for (int i = 0; i < 8; i++) begin
      ctrl({1'b0, i[2], i[1], i[0], 1'b0});
      chk("width mode", {15'h0000, i[0]}, {15'h0000, mode_16});
      d = {12'hA5C, i[3:0]};
      hacc(1'b0, 1'b1, 16'h0010 + 16'(i), d, q16);
      chk("wr space", 16'h0001, {15'h0000, host_wr_space});
      chk("wr addr", 16'h0010 + 16'(i), host_wr_addr);
      chk("wr data", d, host_wr_data);
      hacc(1'b1, 1'b1, 16'h0010 + 16'(i), 16'h0000, q16);
      chk("rd data", d, q16);
    end
    ctrl(5'h02);
    hacc(1'b0, 1'b0, 16'h0001, 16'h5A5A, q16);
    chk("reg space", 16'h0000, {15'h0000, host_wr_space});
    hacc(1'b1, 1'b0, 16'h0001, 16'h0000, q16);
    chk("reg rd", 16'h5A5A, q16);
    hacc(1'b1, 1'b0, 16'h0000, 16'h0000, q16);
    chk("status rd", status, q16);
    av(1'b0, 3'h7, 32'h0000_0000, q);
    chk("unmapped", 16'h0000, q[15:0]);
    ctrl(5'h13);
    chk("mode tr", 16'h0001, {15'h0000, mode_t});
    dma(1'b1, 16'h0021, 16'h3C96);
    @(posedge clk);
    chk("dma idle", 16'h0000, {15'h0000, dma_busy});
    dma(1'b0, 16'h0021, 16'h0000);
    chk("dma rd", 16'h3C96, dma_rdata);
    hacc(1'b0, 1'b1, 16'h0030, 16'h7E81, q16);
    chk("go ignored", 16'h5A5A, host_wr_data);
    ctrl(5'h02);
    hacc(1'b1, 1'b1, 16'h0021, 16'h0000, q16);
    chk("shared ram", 16'h3C96, q16);
    conclude();
  end
endmodule : tb_hpc
